// ==== logic/mbm_engine.sv ====
// ****************************************************************
// Write data buffer
// ****************************************************************
module mbm_fifo
    import mbm_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = FIFO_DEPTH
)(
    input  wire logic             clock_i,
    input  wire logic             rst_n_i,
    input  wire logic             in_valid_i,
    output      logic             in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output      logic             out_valid_o,
    input  wire logic             out_ready_i,
    output      logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW:0]      wp_ff;
    logic [AW:0]      rp_ff;

    assign in_ready_o  = (wp_ff - rp_ff) != (AW+1)'(DEPTH);
    assign out_valid_o = wp_ff != rp_ff;
    assign out_data_o  = mem_ff[rp_ff[AW-1:0]];

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            wp_ff <= '0;
        else if (in_valid_i && in_ready_o)
            wp_ff <= wp_ff + 1'b1;
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            rp_ff <= '0;
        else if (out_valid_o && out_ready_i)
            rp_ff <= rp_ff + 1'b1;
    end

    always_ff @(posedge clock_i)
    begin
        if (in_valid_i && in_ready_o)
            mem_ff[wp_ff[AW-1:0]] <= in_data_i;
    end
endmodule

module mbm_engine
    import mbm_pkg::*;
#(
    parameter int GAP_CYC = GAP_CYCLES
)(
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    input  wire logic        ascii_mode_i,
    input  wire logic [31:0] reply_cycles_i,
    input  wire logic        req_valid_i,
    output      logic        req_ready_o,
    input  wire logic [7:0]  req_slave_i,
    input  wire logic [7:0]  req_func_i,
    input  wire logic [15:0] req_start_i,
    input  wire logic [15:0] req_qty_i,
    input  wire logic        req_bit_i,
    input  wire logic [7:0]  req_nbytes_i,
    input  wire logic        wr_valid_i,
    output      logic        wr_ready_o,
    input  wire logic [7:0]  wr_data_i,
    output      logic        tx_valid_o,
    input  wire logic        tx_ready_i,
    output      logic [7:0]  tx_data_o,
    input  wire logic        rx_valid_i,
    input  wire logic [7:0]  rx_data_i,
    output      logic        rd_valid_o,
    output      logic [7:0]  rd_data_o,
    output      logic        rsp_valid_o,
    output      logic [2:0]  rsp_status_o,
    output      logic [7:0]  rsp_func_o
);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic is_read(input logic [7:0] f);
        return f == FC_RD_OBITS || f == FC_RD_IBITS || f == FC_RD_OWORDS || f == FC_RD_IWORDS;
    endfunction

    function automatic logic is_multi(input logic [7:0] f);
        return f == FC_WR_BITS || f == FC_WR_WORDS;
    endfunction

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++)
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        return r;
    endfunction

    function automatic logic [7:0] hex_char(input logic [3:0] n);
        return (n < 4'ha) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
    endfunction

    function automatic logic [3:0] hex_val(input logic [7:0] c);
        return (c <= 8'h39) ? c[3:0] : 4'(c[3:0] + 4'h9);
    endfunction

    // ****************************************************************
    // Request check
    // ****************************************************************
    logic req_ok;
    logic [15:0] nb16;
    always_comb
    begin
        nb16 = {8'h00, req_nbytes_i};
        case (req_func_i)
            FC_RD_OBITS, FC_RD_IBITS:   req_ok = req_qty_i != 16'h0000;
            FC_RD_OWORDS, FC_RD_IWORDS: req_ok = req_qty_i != 16'h0000
                                               && req_qty_i <= MAX_WORDS;
            FC_WR_BIT, FC_WR_WORD:      req_ok = 1'b1;
            FC_WR_BITS:                 req_ok = req_nbytes_i != 8'h00
                                               && req_nbytes_i <= MAX_WR_BYTES
                                               && nb16 == ((req_qty_i + 16'h0007) >> 3);
            FC_WR_WORDS:                req_ok = req_qty_i != 16'h0000
                                               && req_qty_i <= MAX_WORDS
                                               && nb16 == (req_qty_i << 1);
            default:                    req_ok = 1'b0;
        endcase
        if (is_read(req_func_i) && req_slave_i == BCAST_ADDR)
            req_ok = 1'b0;
    end

    // ****************************************************************
    // Request latch
    // ****************************************************************
    mbm_state_type  state_ff;
    mbm_state_type  nxt_state;
    mbm_status_type status_ff;
    logic [7:0]  slave_ff;
    logic [7:0]  func_ff;
    logic [15:0] start_ff;
    logic [15:0] qty_ff;
    logic [7:0]  nbytes_ff;
    logic        ascii_ff;
    logic [31:0] limit_ff;
    logic        accept;
    logic        bcast;

    assign req_ready_o = state_ff == ST_IDLE;
    assign accept      = req_valid_i && req_ready_o;
    assign bcast       = slave_ff == BCAST_ADDR;

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            slave_ff  <= 8'h01;
            func_ff   <= 8'h00;
            start_ff  <= 16'h0000;
            qty_ff    <= 16'h0000;
            nbytes_ff <= 8'h00;
            ascii_ff  <= 1'b0;
            limit_ff  <= 32'h0000_0000;
        end
        else if (accept)
        begin
            slave_ff  <= req_slave_i;
            func_ff   <= req_func_i;
            start_ff  <= req_start_i;
            qty_ff    <= (req_func_i == FC_WR_BIT) ? (req_bit_i ? BIT_ON : BIT_OFF) : req_qty_i;
            nbytes_ff <= req_nbytes_i;
            ascii_ff  <= ascii_mode_i;
            limit_ff  <= reply_cycles_i;
        end
    end

    // ****************************************************************
    // Transmit framing
    // ****************************************************************
    mbm_phase_type ph_ff;
    mbm_phase_type nxt_ph;
    logic [8:0]  idx_ff;
    logic [15:0] crc_ff;
    logic [7:0]  sum_ff;
    logic        txv_ff;
    logic [7:0]  txd_ff;
    logic [8:0]  hdr_len;
    logic [8:0]  body_len;
    logic [7:0]  cur;
    logic [7:0]  chr;
    logic        is_data;
    logic        last_byte;
    logic        byte_done;
    logic        load;
    logic        send_end;
    logic        fifo_ov;
    logic [7:0]  fifo_od;

    mbm_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clock_i     (clock_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (wr_valid_i),
        .in_ready_o  (wr_ready_o),
        .in_data_i   (wr_data_i),
        .out_valid_o (fifo_ov),
        .out_ready_i (byte_done && is_data),
        .out_data_o  (fifo_od)
    );

    always_comb
    begin
        hdr_len  = is_multi(func_ff) ? 9'd7 : 9'd6;
        body_len = is_multi(func_ff) ? hdr_len + {1'b0, nbytes_ff} : hdr_len;
        is_data  = idx_ff >= hdr_len && idx_ff < body_len;
        case (idx_ff)
            9'd0:    cur = slave_ff;
            9'd1:    cur = func_ff;
            9'd2:    cur = start_ff[15:8];
            9'd3:    cur = start_ff[7:0];
            9'd4:    cur = qty_ff[15:8];
            9'd5:    cur = qty_ff[7:0];
            9'd6:    cur = is_multi(func_ff) ? nbytes_ff : crc_ff[7:0];
            default: cur = crc_ff[7:0];
        endcase
        if (is_data)
            cur = fifo_od;
        else if (idx_ff >= body_len)
            cur = ascii_ff ? 8'(~sum_ff + 8'h01)
                           : (idx_ff == body_len ? crc_ff[7:0] : crc_ff[15:8]);
        last_byte = idx_ff == body_len + (ascii_ff ? 9'd0 : 9'd1);
        chr       = cur;
        nxt_ph    = ph_ff;
        byte_done = 1'b0;
        send_end  = 1'b0;
        if (ascii_ff)
        begin
            case (ph_ff)
                PH_START:
                begin
                    chr    = CH_START;
                    nxt_ph = PH_HI;
                end
                PH_HI:
                begin
                    chr    = hex_char(cur[7:4]);
                    nxt_ph = PH_LO;
                end
                PH_LO:
                begin
                    chr       = hex_char(cur[3:0]);
                    byte_done = 1'b1;
                    nxt_ph    = last_byte ? PH_CR : PH_HI;
                end
                PH_CR:
                begin
                    chr    = CH_CR;
                    nxt_ph = PH_LF;
                end
                default:
                begin
                    chr      = CH_LF;
                    send_end = 1'b1;
                end
            endcase
        end
        else
        begin
            byte_done = 1'b1;
            send_end  = last_byte;
        end
        load = state_ff == ST_SEND && (!txv_ff || tx_ready_i) && !(is_data && !fifo_ov);
        byte_done = byte_done && load;
        send_end  = send_end && load;
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i || accept)
        begin
            idx_ff <= 9'd0;
            ph_ff  <= PH_START;
            crc_ff <= CRC_INIT;
            sum_ff <= 8'h00;
        end
        else if (load)
        begin
            ph_ff <= ascii_ff ? nxt_ph : PH_HI;
            if (byte_done)
            begin
                idx_ff <= idx_ff + 9'd1;
                if (idx_ff < body_len)
                begin
                    crc_ff <= crc_step(crc_ff, cur);
                    sum_ff <= sum_ff + cur;
                end
            end
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            txv_ff <= 1'b0;
            txd_ff <= 8'h00;
        end
        else if (load)
        begin
            txv_ff <= 1'b1;
            txd_ff <= chr;
        end
        else if (tx_ready_i)
            txv_ff <= 1'b0;
    end

    assign tx_valid_o = txv_ff;
    assign tx_data_o  = txd_ff;

    // ****************************************************************
    // Receive parsing
    // ****************************************************************
    logic [8:0]  rn_ff;
    logic [7:0]  raddr_ff;
    logic [7:0]  rfunc_ff;
    logic [15:0] rcrc_ff;
    logic [7:0]  rsum_ff;
    logic [7:0]  h1_ff;
    logic [7:0]  h2_ff;
    logic [3:0]  hi_ff;
    logic        half_ff;
    logic [31:0] gap_ff;
    logic [31:0] wait_ff;
    logic        rdv_ff;
    logic [7:0]  rdd_ff;
    logic        in_wait;
    logic        rb_v;
    logic [7:0]  rb_d;
    logic        r_hex;
    logic        r_sof;
    logic        frame_end;
    logic        chk_good;

    assign in_wait = state_ff == ST_WAIT;
    assign r_hex   = (rx_data_i >= 8'h30 && rx_data_i <= 8'h39)
                  || (rx_data_i >= 8'h41 && rx_data_i <= 8'h46)
                  || (rx_data_i >= 8'h61 && rx_data_i <= 8'h66);
    assign r_sof   = in_wait && rx_valid_i && ascii_ff && rx_data_i == CH_START;
    assign rb_v    = in_wait && rx_valid_i && (!ascii_ff || (r_hex && half_ff));
    assign rb_d    = ascii_ff ? {hi_ff, hex_val(rx_data_i)} : rx_data_i;
    assign frame_end = in_wait && rn_ff != 9'd0
                    && (ascii_ff ? (rx_valid_i && rx_data_i == CH_LF)
                                 : (!rx_valid_i && gap_ff >= 32'(GAP_CYC - 1)));
    assign chk_good  = ascii_ff ? (rsum_ff == 8'h00 && rn_ff >= 9'd3)
                                : (rcrc_ff == 16'h0000 && rn_ff >= 9'd4);

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i || send_end || r_sof)
        begin
            rn_ff    <= 9'd0;
            raddr_ff <= 8'h00;
            rfunc_ff <= 8'h00;
            rcrc_ff  <= CRC_INIT;
            rsum_ff  <= 8'h00;
            h1_ff    <= 8'h00;
            h2_ff    <= 8'h00;
            half_ff  <= 1'b0;
            hi_ff    <= 4'h0;
        end
        else
        begin
            if (in_wait && rx_valid_i && ascii_ff && r_hex)
            begin
                half_ff <= !half_ff;
                hi_ff   <= hex_val(rx_data_i);
            end
            if (rb_v)
            begin
                rn_ff   <= rn_ff + 9'd1;
                rcrc_ff <= crc_step(rcrc_ff, rb_d);
                rsum_ff <= rsum_ff + rb_d;
                h1_ff   <= rb_d;
                h2_ff   <= h1_ff;
                if (rn_ff == 9'd0)
                    raddr_ff <= rb_d;
                if (rn_ff == 9'd1)
                    rfunc_ff <= rb_d;
            end
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i || !in_wait || rx_valid_i)
            gap_ff <= 32'h0000_0000;
        else if (gap_ff < 32'(GAP_CYC))
            gap_ff <= gap_ff + 32'h0000_0001;
    end

    // Payload delayed by the check length so the check is never delivered
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            rdv_ff <= 1'b0;
            rdd_ff <= 8'h00;
        end
        else
        begin
            rdv_ff <= rb_v && (ascii_ff ? rn_ff >= 9'd3 : rn_ff >= 9'd4);
            rdd_ff <= ascii_ff ? h1_ff : h2_ff;
        end
    end

    assign rd_valid_o = rdv_ff;
    assign rd_data_o  = rdd_ff;

    // ****************************************************************
    // Transaction control
    // ****************************************************************
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i || !in_wait)
            wait_ff <= 32'h0000_0000;
        else
            wait_ff <= wait_ff + 32'h0000_0001;
    end

    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: if (accept) nxt_state = req_ok ? ST_SEND : ST_DONE;
            ST_SEND: if (send_end) nxt_state = bcast ? ST_DONE : ST_WAIT;
            ST_WAIT: if (frame_end || wait_ff >= limit_ff) nxt_state = ST_DONE;
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            state_ff <= ST_IDLE;
        else
            state_ff <= nxt_state;
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            status_ff <= RS_OK;
        else if (accept && !req_ok)
            status_ff <= RS_REJECT;
        else if (state_ff == ST_SEND)
            status_ff <= RS_OK;
        else if (frame_end)
        begin
            if (raddr_ff != slave_ff || !chk_good)
                status_ff <= RS_BAD;
            else if (rfunc_ff == func_ff)
                status_ff <= RS_OK;
            else if (rfunc_ff == (func_ff | FC_ERR_FLAG))
                status_ff <= RS_EXC;
            else
                status_ff <= RS_BAD;
        end
        else if (in_wait && wait_ff >= limit_ff)
            status_ff <= RS_TIMEOUT;
    end

    assign rsp_valid_o  = state_ff == ST_DONE;
    assign rsp_status_o = status_ff;
    assign rsp_func_o   = rfunc_ff;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_bad_frame;
        frame_end && raddr_ff != slave_ff;
    endsequence

    sequence s_bad_report;
        rsp_valid_o && rsp_status_o == RS_BAD;
    endsequence

    chk_bcast_no_wait: assert property (in_wait |-> !bcast)
        else $error("broadcast entered reply wait");
    chk_read_addressed: assert property (state_ff == ST_SEND |-> !(is_read(func_ff) && bcast))
        else $error("read sent as broadcast");
    chk_wait_busy: assert property (in_wait |-> !req_ready_o && wait_ff <= limit_ff)
        else $error("new request during reply wait");
    chk_ascii_start: assert property (load && ascii_ff && ph_ff == PH_START
                                      |=> tx_data_o == CH_START)
        else $error("ascii frame without start character");
    chk_rtu_one_char: assert property (load && !ascii_ff |-> byte_done)
        else $error("rtu char not a whole byte");
    chk_bit_status: assert property (load && !ascii_ff && func_ff == FC_WR_BIT && idx_ff == 9'd4
                                     |=> tx_data_o == 8'hff || tx_data_o == 8'h00)
        else $error("bad single bit status");
    chk_start_order: assert property (load && !ascii_ff && idx_ff == 9'd2
                                      |=> tx_data_o == start_ff[15:8])
        else $error("start address not high byte first");
    chk_err_class: assert property (rsp_valid_o && rsp_status_o == RS_EXC
                                    |-> rsp_func_o == (func_ff | FC_ERR_FLAG))
        else $error("error class without flagged code");
    chk_ok_class: assert property (frame_end && chk_good && raddr_ff == slave_ff
                                   && rfunc_ff == func_ff |=> rsp_status_o == RS_OK)
        else $error("matching echo not ok");
    chk_bad_drop: assert property (s_bad_frame |=> s_bad_report)
        else $error("foreign answer not failed");
endmodule

// ==== include/mbm_pkg.sv ====
package mbm_pkg;

    // ****************************************************************
    // Function codes and field values
    // ****************************************************************
    localparam logic [7:0]  FC_RD_OBITS  = 8'h01;
    localparam logic [7:0]  FC_RD_IBITS  = 8'h02;
    localparam logic [7:0]  FC_RD_OWORDS = 8'h03;
    localparam logic [7:0]  FC_RD_IWORDS = 8'h04;
    localparam logic [7:0]  FC_WR_BIT    = 8'h05;
    localparam logic [7:0]  FC_WR_WORD   = 8'h06;
    localparam logic [7:0]  FC_WR_BITS   = 8'h0f;
    localparam logic [7:0]  FC_WR_WORDS  = 8'h10;
    localparam logic [7:0]  FC_ERR_FLAG  = 8'h80;
    localparam logic [7:0]  BCAST_ADDR   = 8'h00;
    localparam logic [15:0] BIT_ON       = 16'hff00;
    localparam logic [15:0] BIT_OFF      = 16'h0000;
    localparam logic [7:0]  MAX_WR_BYTES = 8'hfa;
    localparam logic [15:0] MAX_WORDS    = 16'h007d;

    // ****************************************************************
    // Framing characters and check words
    // ****************************************************************
    localparam logic [7:0]  CH_START = 8'h3a;
    localparam logic [7:0]  CH_CR    = 8'h0d;
    localparam logic [7:0]  CH_LF    = 8'h0a;
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [15:0] CRC_POLY = 16'ha001;

    // ****************************************************************
    // Timing and sizes
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 4;
    localparam int GAP_TIME_NS   = 16000;
    localparam int GAP_CYCLES    = (GAP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FIFO_DEPTH    = 16;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_SEND = 2'h1,
        ST_WAIT = 2'h3,
        ST_DONE = 2'h2
    } mbm_state_type;

    typedef enum logic [2:0] {
        RS_OK      = 3'h0,
        RS_EXC     = 3'h1,
        RS_BAD     = 3'h2,
        RS_TIMEOUT = 3'h3,
        RS_REJECT  = 3'h4
    } mbm_status_type;

    typedef enum logic [2:0] {
        PH_START = 3'h0,
        PH_HI    = 3'h1,
        PH_LO    = 3'h3,
        PH_CR    = 3'h2,
        PH_LF    = 3'h6
    } mbm_phase_type;

endpackage

// ==== verification/mbm_slave.sv ====
// ****************************************************************
// Slave station model: echoes addressed requests in modes 1-2 (mode 2 corrupts byte 3), exception reply in mode 3
// ****************************************************************
module mbm_slave
    import mbm_pkg::*;
(
    input  wire logic       clock_i,
    input  wire logic       tx_valid_i,
    output      logic       tx_ready_o,
    input  wire logic [7:0] tx_data_i,
    input  wire logic [1:0] mode_i,
    output      logic       rx_valid_o,
    output      logic [7:0] rx_data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] frame_q [$];
    int         idle = 0;
    logic [15:0] crc;
    initial
    begin
        tx_ready_o = 1'b0;
        rx_valid_o = 1'b0;
        rx_data_o  = 8'h00;
        forever
        begin
            @(posedge clock_i);
            if (tx_valid_i && tx_ready_o)
            begin
                frame_q.push_back(tx_data_i);
                idle = 0;
            end
            else
                idle++;
            tx_ready_o <= ~tx_ready_o;
            if (idle == 4 && frame_q.size() > 0)
            begin
                if (mode_i == 2'h3)
                begin
                    frame_q = '{frame_q[0], frame_q[1] | FC_ERR_FLAG, 8'h01};
                    crc = CRC_INIT;
                    foreach (frame_q[k])
                    begin
                        crc = crc ^ {8'h00, frame_q[k]};
                        repeat (8) crc = crc[0] ? ((crc >> 1) ^ CRC_POLY) : (crc >> 1);
                    end
                    frame_q.push_back(crc[7:0]);
                    frame_q.push_back(crc[15:8]);
                end
                if (mode_i != 2'h0 && frame_q[0] != BCAST_ADDR)
                    foreach (frame_q[k])
                    begin
                        #1 rx_valid_o = 1'b1;
                        rx_data_o = frame_q[k] ^ {7'h00, mode_i == 2'h2 && k == 3};
                        @(posedge clock_i);
                        #1 rx_valid_o = 1'b0;
                        rx_data_o = ~rx_data_o;
                        @(posedge clock_i);
                    end
                frame_q.delete();
            end
        end
    end
endmodule

// ==== verification/tb_top.sv ====
// ****************************************************************
// Request table, reset, framing and buffer tests
// ****************************************************************
module tb_top
    import mbm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed
    {
        logic [7:0] sl, fc;
        logic [15:0] st, qt;
        logic [7:0] nb;
        logic [1:0] md;
        logic as;
        logic [2:0] ex;
    } mbm_row_type;
    localparam mbm_row_type ROWS [9] = '{
        '{8'h00, 8'h03, 16'h0000, 16'h0001, 8'h00, 2'h0, 1'b0, 3'h4},  // Read to broadcast
        '{8'h01, 8'h07, 16'h0000, 16'h0001, 8'h00, 2'h0, 1'b0, 3'h4},  // Unsupported code
        '{8'h01, 8'h03, 16'h0000, 16'h007e, 8'h00, 2'h0, 1'b0, 3'h4},  // 126 words
        '{8'h01, 8'h0f, 16'h0000, 16'h07d8, 8'hfb, 2'h0, 1'b0, 3'h4},  // 251 bytes
        '{8'h01, 8'h10, 16'h0000, 16'h007e, 8'hfc, 2'h0, 1'b0, 3'h4},  // 126 words
        '{8'h00, 8'h06, 16'h0001, 16'h0002, 8'h00, 2'h0, 1'b0, 3'h0},  // Broadcast write
        '{8'h01, 8'h06, 16'h0001, 16'h0002, 8'h00, 2'h0, 1'b0, 3'h3},  // Silent slave
        '{8'h01, 8'h06, 16'h0001, 16'h0002, 8'h00, 2'h2, 1'b0, 3'h2},  // Corrupted echo
        '{8'h01, 8'h06, 16'h0001, 16'h0002, 8'h00, 2'h3, 1'b0, 3'h1}}; // Exception answer
    localparam logic [7:0] E6 [6] = '{8'h01, 8'h06, 8'h12, 8'h34, 8'hab, 8'hcd};
    mbm_row_type cur = '0;
    logic clock_i = 0, rst_n_i = 0, rqv = 0, wv = 0;
    logic [7:0] wd = 0, txd, rxd, rfc, rdd;
    logic rqr, wr_rdy, txv, txr, rxv, rspv, rdv;
    logic [2:0] st_o;
    logic [7:0] txq [$];
    logic [7:0] rdq [$];
    int fails = 0, comparisons = 0, i;
    mbm_engine #(.GAP_CYC(20)) dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .ascii_mode_i(cur.as),
        .reply_cycles_i(32'd200), .req_valid_i(rqv), .req_ready_o(rqr), .req_slave_i(cur.sl),
        .req_func_i(cur.fc), .req_start_i(cur.st), .req_qty_i(cur.qt), .req_bit_i(cur.qt[0]),
        .req_nbytes_i(cur.nb), .wr_valid_i(wv), .wr_ready_o(wr_rdy), .wr_data_i(wd),
        .tx_valid_o(txv), .tx_ready_i(txr), .tx_data_o(txd), .rx_valid_i(rxv), .rx_data_i(rxd),
        .rd_valid_o(rdv), .rd_data_o(rdd), .rsp_valid_o(rspv), .rsp_status_o(st_o),
        .rsp_func_o(rfc));
    mbm_slave peer (.clock_i(clock_i), .tx_valid_i(txv), .tx_ready_o(txr), .tx_data_i(txd),
        .mode_i(cur.md), .rx_valid_o(rxv), .rx_data_o(rxd));
    always @(posedge clock_i) if (txv && txr) txq.push_back(txd);
    always @(posedge clock_i) if (rdv) rdq.push_back(rdd);
    initial forever #2 clock_i = ~clock_i;
    task check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task give_verdict;
        $display("Comparisons %0d, mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task run(input mbm_row_type r);
        @(posedge clock_i);
        #1 cur = r;
        rqv = 1;
        do @(posedge clock_i); while (rqr !== 1'b1);
        #1 rqv = 0;
        while (rspv !== 1'b1) @(posedge clock_i);
        check(st_o, r.ex);
        repeat (4) @(posedge clock_i);
    endtask
    initial
    begin
        #100000 fails++;
        give_verdict;
    end
    initial
    begin
        repeat (5) @(posedge clock_i);
        #1 rst_n_i = 1;
        check({rqr, wr_rdy, txv, rspv, st_o}, 7'h60);
        check({rdv, rfc}, 9'h000);
        foreach (ROWS[k]) run(ROWS[k]);
        txq.delete();
        rdq.delete();
        run('{8'h01, 8'h06, 16'h1234, 16'habcd, 8'h00, 2'h1, 1'b0, 3'h0});
        check(rfc, FC_WR_WORD);
        check(16'(txq.size()), 8);
        for (i = 0; i < 6; i++) check(txq[i], E6[i]);
        check(16'(rdq.size()), 4);
        for (i = 0; i < 4; i++) check(rdq[i], E6[i + 2]);
        txq.delete();
        run('{8'h01, 8'h06, 16'h1234, 16'habcd, 8'h00, 2'h1, 1'b1, 3'h0});
        check(16'(txq.size()), 17);
        check({txq[0], txq[15]}, {CH_START, CH_CR});
        check({txq[1], txq[2]}, 16'h3031);
        check(txq[16], CH_LF);
        check({txq[13], txq[14]}, 16'h3342);
        txq.delete();
        run('{8'h01, 8'h05, 16'h0007, 16'h0001, 8'h00, 2'h1, 1'b0, 3'h0});
        check({txq[4], txq[5]}, BIT_ON);
        txq.delete();
        run('{8'h01, 8'h05, 16'h0007, 16'h0000, 8'h00, 2'h1, 1'b0, 3'h0});
        check({txq[4], txq[5]}, BIT_OFF);
        for (i = 0; i < 16; i++)
        begin
            @(posedge clock_i);
            #1 wv = 1;
            wd = i[7:0];
        end
        @(posedge clock_i);
        #1 wv = 0;
        check(wr_rdy, 0);
        txq.delete();
        run('{8'h00, 8'h10, 16'h0000, 16'h0008, 8'h10, 2'h0, 1'b0, 3'h0});
        check(16'(txq.size()), 25);
        check({wr_rdy, txq[6]}, 9'h110);
        check(txq[22], 8'h0f);
        give_verdict;
    end
endmodule
